// File: prmcn_defs.vh
// Purpose: Constants for the pin remap and change-notice control block
// Assumes: Word-addressed register port, 16-bit byte offsets
// Notes: Definitions only
`ifndef PRMCN_DEFS_VH
`define PRMCN_DEFS_VH

`define PRMCN_SEL_W 4
`define PRMCN_SEL_RST 4'h0
`define PRMCN_ADDR_W 16
// Output-select registers with printed offsets
`define PRMCN_OFS_G1 16'hfc04
`define PRMCN_OFS_G7 16'hfc0c
`define PRMCN_OFS_G6 16'hfc98
`define PRMCN_OFS_G8 16'hfca0
`define PRMCN_OFS_G9 16'hfca4
// Chosen windows for the remaining registers
`define PRMCN_OFS_INSEL_BASE 16'hfa00
`define PRMCN_OFS_OUTSEL_BASE 16'hfd00
`define PRMCN_OFS_CN_BASE 16'hf600
`define PRMCN_OFS_CFG 16'hf000
// Field positions
`define PRMCN_LOCK_BIT 13
`define PRMCN_CN_ON_BIT 15
`define PRMCN_CN_HALT_BIT 13
`define PRMCN_CN_PORTS 7

`endif

// File: prmcn_pin_remap.v
// Purpose: Pin remap selects, global map lock and per-port change-notice
//          control registers
// Assumes: Single clock, synchronous active-high reset, one-cycle strobes
// Notes: Select decode tables are parameters; outputs are registered
//
// Function
// RULE1 - Each peripheral input has a read/write 4-bit pin select field
// RULE2 - Each remappable pin has a read/write 4-bit output function select
// RULE3 - Select register writes are ignored while the map lock bit is set
// RULE4 - Select registers read bits 31..4 as zero and ignore their writes
// RULE5 - Every select register clears to zero on reset
// RULE6 - Selects for absent pins are not implemented
// RULE7 - One change-notice control register per port, A through G
// RULE8 - Bit 15 enables change-notice on that port, resets to zero
// RULE9 - Bit 13 halts that port's change-notice while the CPU idles
// RULE10 - Change-notice control reads zero except bits 15 and 13
// RULE11 - Select decode is a parameter table; reserved codes disconnect
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "prmcn_defs.vh"

module prmcn_pin_remap #(
    parameter NUM_IN = 4,
    parameter NUM_PIN = 16,
    parameter NUM_FN = 15,
    // Present mask for output selects; a zero bit drops that register
    parameter [15:0] PIN_PRESENT = 16'hffff,
    // Per input: 16 codes x 4-bit pin index, code valid mask
    parameter [NUM_IN*64-1:0] IN_MAP = {4{64'hfedcba9876543210}},
    parameter [NUM_IN*16-1:0] IN_VALID = {4{16'h7fff}},
    // Per pin: valid mask of 16 codes; code n means function n-1
    parameter [NUM_PIN*16-1:0] OUT_VALID = {16{16'h7ffe}}
) (
    input wire clk,
    input wire sys_rst,
    input wire [15:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdata,
    input wire cpuIdle,
    input wire [NUM_PIN-1:0] pinLevel,
    input wire [NUM_FN-1:0] fnOut,
    output reg [NUM_IN-1:0] periphIn,
    output reg [NUM_PIN-1:0] pinOut,
    output reg [NUM_PIN-1:0] pinMapped,
    output reg pinMapLock,
    output reg [`PRMCN_CN_PORTS-1:0] changeNoticeActive
);

    reg [`PRMCN_SEL_W-1:0] inSel [0:NUM_IN-1];
    reg [`PRMCN_SEL_W-1:0] outSel [0:NUM_PIN-1];
    reg [`PRMCN_CN_PORTS-1:0] cnOn;
    reg [`PRMCN_CN_PORTS-1:0] cnHalt;
    reg [NUM_PIN-1:0] pinSync1;
    reg [NUM_PIN-1:0] pinSync2;
    reg cpuIdleSync1;
    reg cpuIdleSync2;
    reg [31:0] next_regRdata;
    wire selWriteOk;
    integer k;

    // Pins come from outside the clock domain
    always @(posedge clk)
    begin
        pinSync1 <= pinLevel;
        pinSync2 <= pinSync1;
        cpuIdleSync1 <= cpuIdle;
        cpuIdleSync2 <= cpuIdleSync1;
    end

    assign selWriteOk = regWrite && !pinMapLock; // RULE3

    // Global lock in the chosen config register
    always @(posedge clk)
    begin
        if (sys_rst)
            pinMapLock <= 1'b0;
        else if (regWrite && regAddr == `PRMCN_OFS_CFG)
            pinMapLock <= regWdata[`PRMCN_LOCK_BIT];
    end

    genvar i;
    generate
        for (i = 0; i < NUM_IN; i = i + 1)
        begin : gIn
            wire [`PRMCN_ADDR_W-1:0] inAddr;
            wire [31:0] inAddrFull;
            wire [3:0] code;
            wire [3:0] pinIdx;
            assign inAddrFull = `PRMCN_OFS_INSEL_BASE + i * 4;
            assign inAddr = inAddrFull[`PRMCN_ADDR_W-1:0];
            assign code = inSel[i];
            assign pinIdx = IN_MAP[i*64 + code*4 +: 4];
            always @(posedge clk)
            begin
                if (sys_rst)
                    inSel[i] <= `PRMCN_SEL_RST; // RULE5
                else if (selWriteOk && regAddr == inAddr)
                    inSel[i] <= regWdata[`PRMCN_SEL_W-1:0]; // RULE1 RULE4
            end
            // Reserved code leaves the input low, not floating
            always @(posedge clk)
            begin
                if (sys_rst)
                    periphIn[i] <= 1'b0;
                else if (IN_VALID[i*16 + code] && pinIdx < NUM_PIN)
                    periphIn[i] <= pinSync2[pinIdx]; // RULE11
                else
                    periphIn[i] <= 1'b0; // RULE11
            end
        end
        for (i = 0; i < NUM_PIN; i = i + 1)
        begin : gPin
            wire [`PRMCN_ADDR_W-1:0] pinAddr;
            wire [31:0] pinAddrFull;
            wire [3:0] code;
            wire [3:0] fnIdx;
            wire codeOk;
            assign pinAddrFull = `PRMCN_OFS_OUTSEL_BASE + i * 4;
            assign pinAddr = (i == 1) ? `PRMCN_OFS_G1 :
                             (i == 6) ? `PRMCN_OFS_G6 :
                             (i == 7) ? `PRMCN_OFS_G7 :
                             (i == 8) ? `PRMCN_OFS_G8 :
                             (i == 9) ? `PRMCN_OFS_G9 :
                             pinAddrFull[`PRMCN_ADDR_W-1:0];
            assign code = outSel[i];
            assign fnIdx = code - 4'h1;
            assign codeOk = OUT_VALID[i*16 + code] && fnIdx < NUM_FN;
            always @(posedge clk)
            begin
                if (sys_rst || !PIN_PRESENT[i])
                    outSel[i] <= `PRMCN_SEL_RST; // RULE5 RULE6
                else if (selWriteOk && regAddr == pinAddr)
                    outSel[i] <= regWdata[`PRMCN_SEL_W-1:0]; // RULE2 RULE4
            end
            // Unmapped pin hands back to the port latch via pinMapped
            always @(posedge clk)
            begin
                if (sys_rst)
                begin
                    pinOut[i] <= 1'b0;
                    pinMapped[i] <= 1'b0;
                end
                else
                begin
                    pinMapped[i] <= PIN_PRESENT[i] && codeOk; // RULE11
                    pinOut[i] <= codeOk ? fnOut[fnIdx] : 1'b0; // RULE11
                end
            end
        end
        for (i = 0; i < `PRMCN_CN_PORTS; i = i + 1)
        begin : gCn
            wire [`PRMCN_ADDR_W-1:0] cnAddr;
            wire [31:0] cnAddrFull;
            assign cnAddrFull = `PRMCN_OFS_CN_BASE + i * 16;
            assign cnAddr = cnAddrFull[`PRMCN_ADDR_W-1:0];
            always @(posedge clk)
            begin
                if (sys_rst)
                begin
                    cnOn[i] <= 1'b0; // RULE8
                    cnHalt[i] <= 1'b0;
                    changeNoticeActive[i] <= 1'b0;
                end
                else
                begin
                    if (regWrite && regAddr == cnAddr) // RULE7
                    begin
                        cnOn[i] <= regWdata[`PRMCN_CN_ON_BIT]; // RULE8
                        cnHalt[i] <= regWdata[`PRMCN_CN_HALT_BIT]; // RULE9
                    end
                    // Idle only matters when halt is requested
                    changeNoticeActive[i] <= cnOn[i] &&
                        !(cnHalt[i] && cpuIdleSync2); // RULE8 RULE9
                end
            end
        end
    endgenerate

    function [15:0] gPinAddr;
        input integer n;
        begin
            case (n)
                1: gPinAddr = `PRMCN_OFS_G1;
                6: gPinAddr = `PRMCN_OFS_G6;
                7: gPinAddr = `PRMCN_OFS_G7;
                8: gPinAddr = `PRMCN_OFS_G8;
                9: gPinAddr = `PRMCN_OFS_G9;
                default: gPinAddr = `PRMCN_OFS_OUTSEL_BASE + n[15:0] * 16'h4;
            endcase
        end
    endfunction

    // Read mux; unmapped addresses read as zero
    always @*
    begin
        next_regRdata = 32'h0;
        if (regAddr == `PRMCN_OFS_CFG)
            next_regRdata[`PRMCN_LOCK_BIT] = pinMapLock;
        for (k = 0; k < NUM_IN; k = k + 1)
            if (regAddr == `PRMCN_OFS_INSEL_BASE + k * 4)
                next_regRdata[3:0] = inSel[k]; // RULE4
        for (k = 0; k < NUM_PIN; k = k + 1)
            if (PIN_PRESENT[k] && regAddr == gPinAddr(k))
                next_regRdata[3:0] = outSel[k]; // RULE4 RULE6
        for (k = 0; k < `PRMCN_CN_PORTS; k = k + 1)
            if (regAddr == `PRMCN_OFS_CN_BASE + k * 16)
            begin
                next_regRdata[`PRMCN_CN_ON_BIT] = cnOn[k]; // RULE10
                next_regRdata[`PRMCN_CN_HALT_BIT] = cnHalt[k]; // RULE10
            end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
            regRdata <= 32'h0;
        else if (regRead)
            regRdata <= next_regRdata;
        else
            regRdata <= 32'h0;
    end

endmodule // prmcn_pin_remap

// File: prmcn_pin_remap_checker.sv
// Purpose: Port assertions for the pin remap block
// Assumes: One clock, synchronous active-high reset
// Notes: Address figures follow the chosen register map
`timescale 1ns/1ps
module prmcn_pin_remap_checker #(
    parameter NUM_IN = 4,
    parameter NUM_PIN = 16,
    parameter NUM_FN = 15
) (
    input wire clk,
    input wire sys_rst,
    input wire [15:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWrite,
    input wire regRead,
    input wire [31:0] regRdata,
    input wire cpuIdle,
    input wire [NUM_PIN-1:0] pinLevel,
    input wire [NUM_FN-1:0] fnOut,
    input wire [NUM_IN-1:0] periphIn,
    input wire [NUM_PIN-1:0] pinOut,
    input wire [NUM_PIN-1:0] pinMapped,
    input wire pinMapLock,
    input wire [6:0] changeNoticeActive
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sel_upper_zero_a:
    assert property (regRead && regAddr == 16'hfc04 |=> regRdata[31:4] == 0)
        else $error("Select upper bits not zero");
    notice_rsvd_zero_a:
    assert property (regRead && regAddr == 16'hf600
        |=> (regRdata & 32'hffff5fff) == 0) else $error("Reserved bits set");
    lock_set_a:
    assert property (regWrite && regAddr == 16'hf000 && regWdata[13]
        |=> pinMapLock) else $error("Lock did not set");
    lock_clear_a:
    assert property (regWrite && regAddr == 16'hf000 && !regWdata[13]
        |=> !pinMapLock) else $error("Lock did not clear");
    notice_on_a:
    assert property (regWrite && regAddr == 16'hf600 && regWdata[15]
        && !regWdata[13] |-> ##2 changeNoticeActive[0]) else $error("Not on");
    notice_off_a:
    assert property (regWrite && regAddr == 16'hf600 && !regWdata[15]
        |-> ##2 !changeNoticeActive[0]) else $error("Not off");
    reset_clear_a:
    assert property ($fell(sys_rst) |-> !pinMapLock && pinOut == 0
        && changeNoticeActive == 0) else $error("Outputs not cleared");
    unmapped_zero_a:
    assert property (regRead && regAddr == 16'h0100 |=> regRdata == 0)
        else $error("Unmapped read not zero");
endmodule // prmcn_pin_remap_checker

bind prmcn_pin_remap prmcn_pin_remap_checker #(.NUM_IN(NUM_IN),
    .NUM_PIN(NUM_PIN), .NUM_FN(NUM_FN)) chk_u (.*);

// File: tb_prmcn_pin_remap.sv
// Purpose: Register level test of the pin remap block
// Assumes: Default parameters, 50 MHz clock
// Notes: Waits cover the two-flop input synchronisers
`timescale 1ns/1ps
module tb_prmcn_pin_remap;
    localparam [127:0] SEL = {16'hfc04, 16'hfc0c, 16'hfc98, 16'hfca0,
        16'hfca4, 16'hfa00, 16'hfd00, 16'hf000};
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [15:0] regAddr = 16'h0;
    reg [31:0] regWdata = 32'h0;
    reg regWrite = 1'b0;
    reg regRead = 1'b0;
    reg cpuIdle = 1'b0;
    reg [15:0] pinLevel = 16'h0008;
    reg [14:0] fnOut = 15'h0010;
    wire [31:0] regRdata;
    wire [3:0] periphIn;
    wire [15:0] pinOut;
    wire [15:0] pinMapped;
    wire pinMapLock;
    wire [6:0] changeNoticeActive;
    integer num_errors = 0;
    integer check_count = 0;
    integer cycles = 0;
    integer i;
    always #10 clk = ~clk;
    prmcn_pin_remap dut_u (.*);
    task chk(input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task wr(input [15:0] a, input [31:0] d);
    begin
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    end
    endtask
    // Read data stand one cycle only, so sample just after the edge
    task rd(input [15:0] a, input [31:0] e);
    begin
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regRdata, e);
    end
    endtask
    task report_and_stop;
    begin
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            num_errors = num_errors + 1;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i = i + 1)
            rd(SEL[i*16 +: 16], 32'h0);
        for (i = 0; i < 7; i = i + 1)
            rd(16'hf600 + 16'(i << 4), 32'h0);
        $display("reset test done");
        wr(16'hfc04, 32'hfffffff5);
        rd(16'hfc04, 32'h5);
        wr(16'hfa00, 32'hfffffff3);
        rd(16'hfa00, 32'h3);
        wr(16'h0100, 32'hffffffff);
        rd(16'h0100, 32'h0);
        repeat (6) @(posedge clk);
        #1 chk({31'h0, pinOut[1]}, 32'h1);
        chk({31'h0, periphIn[0]}, 32'h1);
        chk({31'h0, pinMapped[1]}, 32'h1);
        chk({16'h0, pinMapped & 16'hfffd}, 32'h0);
        $display("select test done");
        wr(16'hf000, 32'h2000);
        rd(16'hf000, 32'h2000);
        chk({31'h0, pinMapLock}, 32'h1);
        wr(16'hfc04, 32'h9);
        wr(16'hfa00, 32'h1);
        rd(16'hfc04, 32'h5);
        rd(16'hfa00, 32'h3);
        wr(16'hf000, 32'h0);
        wr(16'hfc04, 32'h9);
        rd(16'hfc04, 32'h9);
        $display("lock test done");
        wr(16'hf600, 32'h8000);
        wr(16'hf610, 32'hffffffff);
        rd(16'hf610, 32'ha000);
        repeat (4) @(posedge clk);
        #1 chk({25'h0, changeNoticeActive}, 32'h3);
        @(posedge clk);
        cpuIdle <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk({25'h0, changeNoticeActive}, 32'h1);
        wr(16'hf600, 32'h0);
        repeat (3) @(posedge clk);
        #1 chk({25'h0, changeNoticeActive}, 32'h0);
        $display("notice test done");
        report_and_stop;
    end
endmodule // tb_prmcn_pin_remap
